// file: mfio_pkg.sv
// package: register map, field layouts and mode encodings for the i/o pin block
package mfio_pkg;
  // register byte offsets
  localparam logic [11:0] REG_PIN_FUNC   = 12'h000;
  localparam logic [11:0] REG_OUT_SEL    = 12'h004;
  localparam logic [11:0] REG_ALARM_CFG  = 12'h008;
  localparam logic [11:0] REG_ALARM_THR  = 12'h00c;
  localparam logic [11:0] REG_SCALE_GAIN = 12'h010;
  localparam logic [11:0] REG_SCALE_OFFS = 12'h014;
  localparam logic [11:0] REG_LASER_CTL  = 12'h018;
  localparam logic [11:0] REG_STATUS     = 12'h01c;
  localparam logic [11:0] REG_FREE_VAL   = 12'h020;
  localparam logic [11:0] REG_SLOPE_VAL  = 12'h024;
  localparam logic [11:0] REG_EMIS_VAL   = 12'h028;
  localparam logic [11:0] REG_OUT1_VAL   = 12'h02c;
  localparam logic [11:0] REG_OUT2_VAL   = 12'h030;
  localparam logic [11:0] REG_AMB_LIMIT  = 12'h034;
  // field positions
  localparam int OUT_SEL1_LSB   = 0;
  localparam int OUT_SEL2_LSB   = 4;
  localparam int OUT_RNG1_BIT   = 8;
  localparam int OUT_RNG2_BIT   = 9;
  localparam int ALM_SRC_LSB    = 0;
  localparam int ALM_HIGH_BIT   = 4;
  localparam int ALM_NC_BIT     = 5;
  // reset values
  localparam logic [3:0]  RST_PIN_FUNC  = 4'h0;
  localparam logic [15:0] RST_SCALE_GAIN = 16'h0100;
  localparam logic [15:0] RST_AMB_LIMIT  = 16'h01f4;
  // pin functions
  typedef enum logic [3:0] {
    FN_ALARM, FN_GATE_LOW, FN_GATE_HIGH, FN_HOLD_RISE, FN_HOLD_FALL,
    FN_RST_FALL, FN_RST_RISE, FN_SLOPE_EXT, FN_EMIS_EXT, FN_FREE_VAL,
    FN_LASER_LOW, FN_LASER_HIGH
  } mfio_func_t;
  // signal sources
  typedef enum logic [2:0] {
    SRC_PROC, SRC_RATIO, SRC_DET_ONE, SRC_DET_TWO, SRC_ATTEN, SRC_DET_TEMP
  } mfio_src_t;
endpackage

// file: mfio_pin_control.sv
// multifunction i/o pin control with apb register file
`timescale 1ns/1ps

// the apb slave answers with no wait states: pready is tied high, so
// every access phase ends in its first cycle; a write issued while
// clkEn is low is lost, because the register file freezes with the
// rest of the block
module mfio_pin_control
  import mfio_pkg::*;
#(
  parameter int DW = 16
) (
  // clock, reset, enable
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          clkEn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic               pslverr,
  output logic [31:0]        prdata,
  // measurement core values
  input  wire logic [DW-1:0] procTemp,
  input  wire logic [DW-1:0] ratioTemp,
  input  wire logic [DW-1:0] detector_one_temperature,
  input  wire logic [DW-1:0] detector_two_temperature,
  input  wire logic [DW-1:0] attenPct,
  input  wire logic [DW-1:0] detTemp,
  input  wire logic [DW-1:0] ambientTemp,
  input  wire logic [DW-1:0] pinAdc,
  // i/o pin, open collector
  input  wire logic          ioPinIn,
  output logic               ioPinOut,
  output logic               ioPinOe,
  // outputs to the plant side
  output logic [DW-1:0]      out1Val_ff,
  output logic [DW-1:0]      out2Val_ff,
  output logic               out1Base4mA,
  output logic               out2Base4mA,
  output logic               peakReset,
  output logic               laserOn_ff,
  output logic [DW-1:0]      slopeVal_ff,
  output logic [DW-1:0]      emisVal_ff
);

  // software registers
  logic [3:0]    pinFunc_ff;
  logic [9:0]    outSel_ff;
  logic [5:0]    alarmCfg_ff;
  logic [DW-1:0] alarmThr_ff;
  logic [DW-1:0] scaleGain_ff;
  logic [DW-1:0] scaleOffs_ff;
  logic          laserSw_ff;
  logic [DW-1:0] ambLimit_ff;
  logic [DW-1:0] freeVal_ff;
  // pin synchroniser and edge state
  logic [2:0]    pinSync_ff;
  logic          pinLvl_ff;
  logic          riseEv;
  logic          fallEv;
  logic          frozen_ff;
  logic          alarm_ff;
  logic [DW-1:0] nxt_scaled;
  logic [2*DW-1:0] prod;
  logic          apbWr;
  mfio_func_t    fn;
  logic [3:0]    fnPrev_ff;
  logic          fnEntry;
  logic [DW-1:0] alarmSrc;

  // pick one of the six measurement signals; codes six and seven are
  // unused and fall back to the process value rather than an unknown
  function automatic logic [DW-1:0] srcMux(input logic [2:0] s);
    unique case (s)
      SRC_PROC:     srcMux = procTemp;
      SRC_RATIO:    srcMux = ratioTemp;
      SRC_DET_ONE:  srcMux = detector_one_temperature;
      SRC_DET_TWO:  srcMux = detector_two_temperature;
      SRC_ATTEN:    srcMux = attenPct;
      SRC_DET_TEMP: srcMux = detTemp;
      default:      srcMux = procTemp;
    endcase
  endfunction

  assign fn     = mfio_func_t'(pinFunc_ff);
  assign apbWr  = psel & penable & pwrite & clkEn;
  assign pready = 1'b1;
  // unmapped offsets answer with an error, never a silent drop
  always_comb begin
    unique case (paddr)
      REG_PIN_FUNC, REG_OUT_SEL, REG_ALARM_CFG, REG_ALARM_THR,
      REG_SCALE_GAIN, REG_SCALE_OFFS, REG_LASER_CTL, REG_STATUS,
      REG_FREE_VAL, REG_SLOPE_VAL, REG_EMIS_VAL, REG_OUT1_VAL,
      REG_OUT2_VAL, REG_AMB_LIMIT: pslverr = 1'b0;
      default: pslverr = psel & penable;
    endcase
  end

  // register writes
  // read-only and unmapped offsets land in the default arm and drop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinFunc_ff   <= RST_PIN_FUNC;
      outSel_ff    <= '0;
      alarmCfg_ff  <= '0;
      alarmThr_ff  <= '0;
      scaleGain_ff <= RST_SCALE_GAIN;
      scaleOffs_ff <= '0;
      laserSw_ff   <= 1'b0;
      ambLimit_ff  <= RST_AMB_LIMIT;
    end else if (apbWr) begin
      unique case (paddr)
        REG_PIN_FUNC:   pinFunc_ff   <= pwdata[3:0];
        REG_OUT_SEL:    outSel_ff    <= pwdata[9:0];
        REG_ALARM_CFG:  alarmCfg_ff  <= pwdata[5:0];
        REG_ALARM_THR:  alarmThr_ff  <= pwdata[DW-1:0];
        REG_SCALE_GAIN: scaleGain_ff <= pwdata[DW-1:0];
        REG_SCALE_OFFS: scaleOffs_ff <= pwdata[DW-1:0];
        REG_LASER_CTL:  laserSw_ff   <= pwdata[0];
        REG_AMB_LIMIT:  ambLimit_ff  <= pwdata[DW-1:0];
        default: ;
      endcase
    end
  end

  // read mux; status shows pin level, alarm, laser and freeze
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      REG_PIN_FUNC:   prdata[3:0] = pinFunc_ff;
      REG_OUT_SEL:    prdata[9:0] = outSel_ff;
      REG_ALARM_CFG:  prdata[5:0] = alarmCfg_ff;
      REG_ALARM_THR:  prdata[DW-1:0] = alarmThr_ff;
      REG_SCALE_GAIN: prdata[DW-1:0] = scaleGain_ff;
      REG_SCALE_OFFS: prdata[DW-1:0] = scaleOffs_ff;
      REG_LASER_CTL:  prdata[0] = laserSw_ff;
      REG_STATUS:     prdata[3:0] = {frozen_ff, laserOn_ff, alarm_ff,
                                     pinLvl_ff};
      REG_FREE_VAL:   prdata[DW-1:0] = freeVal_ff;
      REG_SLOPE_VAL:  prdata[DW-1:0] = slopeVal_ff;
      REG_EMIS_VAL:   prdata[DW-1:0] = emisVal_ff;
      REG_OUT1_VAL:   prdata[DW-1:0] = out1Val_ff;
      REG_OUT2_VAL:   prdata[DW-1:0] = out2Val_ff;
      REG_AMB_LIMIT:  prdata[DW-1:0] = ambLimit_ff;
      default: ;
    endcase
  end

  // three-stage synchroniser; level changes when stages 2 and 3 agree
  // the agreement test filters a one-sample glitch on a slow pin edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinSync_ff <= '0;
      pinLvl_ff  <= 1'b0;
    end else if (clkEn) begin
      pinSync_ff <= {pinSync_ff[1:0], ioPinIn};
      if (pinSync_ff[1] == pinSync_ff[2])
        pinLvl_ff <= pinSync_ff[2];
    end
  end

  // single-cycle edge events from the filtered level; gated by clkEn,
  // since a frozen level would otherwise repeat the event every cycle
  assign riseEv = clkEn & (pinSync_ff[1] == pinSync_ff[2]) &
                  pinSync_ff[2] & ~pinLvl_ff;
  assign fallEv = clkEn & (pinSync_ff[1] == pinSync_ff[2]) &
                  ~pinSync_ff[2] & pinLvl_ff;

  // function seen one cycle ago; a difference marks entry into a mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fnPrev_ff <= RST_PIN_FUNC;
    end else if (clkEn) begin
      fnPrev_ff <= pinFunc_ff;
    end
  end
  assign fnEntry = (pinFunc_ff != fnPrev_ff);

  // freeze state for gate and edge-hold functions; an edge-hold mode
  // starts out tracking, even when the mode before it had frozen, and
  // an edge in the entry cycle still wins over that re-arm
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frozen_ff <= 1'b0;
    end else if (clkEn) begin
      unique case (fn)
        FN_GATE_LOW:  frozen_ff <= pinLvl_ff;
        FN_GATE_HIGH: frozen_ff <= ~pinLvl_ff;
        FN_HOLD_RISE: begin
          if (riseEv)
            frozen_ff <= 1'b1;
          else if (fnEntry)
            frozen_ff <= 1'b0;
        end
        FN_HOLD_FALL: begin
          if (fallEv)
            frozen_ff <= 1'b1;
          else if (fnEntry)
            frozen_ff <= 1'b0;
        end
        default:      frozen_ff <= 1'b0;
      endcase
    end
  end

  // edge-hold stays frozen until the function changes; a later edge
  // does not resume tracking, which keeps the held value stable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out1Val_ff <= '0;
      out2Val_ff <= '0;
    end else if (clkEn && !frozen_ff) begin
      out1Val_ff <= srcMux(outSel_ff[OUT_SEL1_LSB +: 3]);
      out2Val_ff <= srcMux(outSel_ff[OUT_SEL2_LSB +: 3]);
    end
  end

  // range bits go straight out: 1 selects the 4 mA lower end
  assign out1Base4mA = outSel_ff[OUT_RNG1_BIT];
  assign out2Base4mA = outSel_ff[OUT_RNG2_BIT];

  // accumulator clear pulse toward the peak/valley hold in the core
  assign peakReset = (fn == FN_RST_FALL && fallEv) ||
                     (fn == FN_RST_RISE && riseEv);

  // linear scaling of the pin voltage: gain in 8.8 fixed point plus offset
  // the sum wraps at DW bits; software keeps gain and offset in range
  assign prod       = pinAdc * scaleGain_ff;
  assign nxt_scaled = prod[DW+7:8] + scaleOffs_ff;

  // analog input functions; values hold when the function is not selected
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slopeVal_ff <= '0;
      emisVal_ff  <= '0;
      freeVal_ff  <= '0;
    end else if (clkEn) begin
      if (fn == FN_SLOPE_EXT)
        slopeVal_ff <= nxt_scaled;
      if (fn == FN_EMIS_EXT)
        emisVal_ff <= nxt_scaled;
      // the free value is the raw pin code: scaling is for slope and
      // emissivity only, and nothing here feeds the measurement
      if (fn == FN_FREE_VAL)
        freeVal_ff <= pinAdc;
    end
  end

  // laser request from pin or software, vetoed by hot ambient
  // the veto is tested first so no pin level or software bit beats it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      laserOn_ff <= 1'b0;
    end else if (clkEn) begin
      if (ambientTemp > ambLimit_ff)
        laserOn_ff <= 1'b0;
      else if (fn == FN_LASER_LOW)
        laserOn_ff <= ~pinLvl_ff;
      else if (fn == FN_LASER_HIGH)
        laserOn_ff <= pinLvl_ff;
      else
        laserOn_ff <= laserSw_ff;
    end
  end

  // alarm comparison against the threshold
  assign alarmSrc = srcMux(alarmCfg_ff[ALM_SRC_LSB +: 3]);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      alarm_ff <= 1'b0;
    end else if (clkEn) begin
      // strict compares: a source equal to the threshold raises nothing
      if (alarmCfg_ff[ALM_HIGH_BIT])
        alarm_ff <= alarmSrc > alarmThr_ff;
      else
        alarm_ff <= alarmSrc < alarmThr_ff;
    end
  end

  // open collector: only pulls low; normally-closed inverts the sense
  // nothing drives the pin high, so the plant pull-up sets idle level
  assign ioPinOut = 1'b0;
  assign ioPinOe  = (fn == FN_ALARM) &
                    (alarm_ff ^ alarmCfg_ff[ALM_NC_BIT]);

endmodule

// file: mfio_pin_control_chk.sv
// checker: port assertions for the i/o pin control block
`timescale 1ns/1ps
module mfio_chk
  import mfio_pkg::*;
#(parameter int DW = 16) (
  // clock domain
  input wire logic          clock,
  input wire logic          sys_rst,
  input wire logic          clkEn,
  // watched ports
  input wire logic [DW-1:0] ambientTemp,
  input wire logic          ioPinOut,
  input wire logic          ioPinOe,
  input wire logic [DW-1:0] out1Val_ff,
  input wire logic [DW-1:0] out2Val_ff,
  input wire logic          peakReset,
  input wire logic          laserOn_ff,
  input wire logic [DW-1:0] slopeVal_ff,
  input wire logic [DW-1:0] emisVal_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // open collector: the pin is only ever pulled low
  pin_low_a: assert property (!ioPinOut)
    else $error("pin driven high");
  one_pulse_a: assert property (peakReset |=> !peakReset)
    else $error("clear pulse too long");
  pull_or_clear_a: assert property (!(peakReset && ioPinOe))
    else $error("alarm and clear at once");
  // uses the reset limit only: the bench never rewrites it
  laser_veto_a: assert property (clkEn && ambientTemp > RST_AMB_LIMIT
    |=> !laserOn_ff) else $error("laser on when hot");
  hold_out_a: assert property (!clkEn |=> $stable(out1Val_ff)
    && $stable(out2Val_ff) && $stable(laserOn_ff)) else $error("out moved");
  hold_meas_a: assert property (!clkEn |=> $stable(slopeVal_ff)
    && $stable(emisVal_ff)) else $error("scaled value moved");
  one_input_a: assert property (!($changed(slopeVal_ff)
    && $changed(emisVal_ff))) else $error("two inputs at once");
  slope_quiet_a: assert property ($changed(slopeVal_ff)
    |-> !$past(ioPinOe)) else $error("slope moved in alarm mode");
  cover property (peakReset);
  cover property (laserOn_ff);
  cover property (ioPinOe);
endmodule

bind mfio_pin_control mfio_chk #(.DW(DW)) mfio_chk_inst (.clock, .sys_rst,
  .clkEn, .ambientTemp, .ioPinOut, .ioPinOe, .out1Val_ff, .out2Val_ff,
  .peakReset, .laserOn_ff, .slopeVal_ff, .emisVal_ff);

// file: mfio_plant.sv
// plant model: equipment wired to the shared i/o pin
`timescale 1ns/1ps
module mfio_plant (
  // plant drive and device pull-down
  input  wire logic plantLvl,
  input  wire logic ioPinOe,
  // resolved pin level
  output logic      ioPinIn
);
  // wired line: the device pull-down wins over the plant
  assign ioPinIn = plantLvl && !ioPinOe;
endmodule

// file: test_multifunction_io_pin_control.sv
// testbench: multifunction i/o pin control scenarios
`timescale 1ns/1ps
module test_multifunction_io_pin_control;
  import mfio_pkg::*;
  logic        clock, sys_rst, clkEn, psel, penable, pwrite, plantLvl, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [15:0] src [6];
  logic [15:0] ambientTemp, pinAdc;
  wire         pready, pslverr, ioPinIn, ioPinOut, ioPinOe, peakReset;
  wire         laserOn_ff, out1Base4mA, out2Base4mA;
  wire  [31:0] prdata;
  wire  [15:0] out1Val_ff, out2Val_ff, slopeVal_ff, emisVal_ff;
  int          num_errors, comparisons, cyc, pulses;

  mfio_pin_control mfio_pin_control_inst (.clock, .sys_rst, .clkEn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .procTemp(src[0]), .ratioTemp(src[1]),
    .detector_one_temperature(src[2]), .detector_two_temperature(src[3]),
    .attenPct(src[4]), .detTemp(src[5]), .ambientTemp, .pinAdc, .ioPinIn,
    .ioPinOut, .ioPinOe, .out1Val_ff, .out2Val_ff, .out1Base4mA,
    .out2Base4mA, .peakReset, .laserOn_ff, .slopeVal_ff, .emisVal_ff);
  mfio_plant mfio_plant_inst (.plantLvl, .ioPinOe, .ioPinIn);

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // cycle ceiling, and a count of clear pulses
  always @(posedge clock) begin
    cyc++;
    if (peakReset === 1'h1) pulses++;
    if (cyc > 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one transfer; an idle edge after it keeps drives one per time step
  task automatic apb(logic [11:0] a, logic [31:0] d, logic w = 1'h1);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  // plant sets the pin, then leaves time for sync and output stages
  task automatic pin(logic v);
    plantLvl <= v;
    repeat (8) @(posedge clock);
  endtask

  task automatic t_outsel();
    for (int s = 0; s < 6; s++) begin
      apb(REG_OUT_SEL, 32'(s) | 32'(5 - s) << 4 | 32'(s % 4) << 8);
      @(posedge clock);
      chk("outs", {src[s], src[5 - s]}, {out1Val_ff, out2Val_ff});
      chk("range", s % 4, {out2Base4mA, out1Base4mA});
    end
    apb(12'h040, 32'h0, 1'h0);
    chk("unmapped", 32'h2, {err, |rdata});
  endtask
  task automatic t_gate();
    for (int m = 0; m < 2; m++) begin
      pin(!m[0]);
      apb(REG_PIN_FUNC, 32'(FN_GATE_LOW) + 32'(m));
      pin(m[0]);
      src[0] <= 16'h1230 + 16'(m);
      pin(!m[0]);
      src[0] <= 16'h0bad;
      pin(!m[0]);
      chk("gate", 16'h1230 + 16'(m), out2Val_ff);
    end
  endtask
  // edge hold stays frozen across the opposite edge too
  task automatic t_hold();
    for (int m = 0; m < 2; m++) begin
      pin(m[0]);
      apb(REG_PIN_FUNC, 32'(FN_HOLD_RISE) + 32'(m));
      src[0] <= 16'h0300 + 16'(m);
      pin(!m[0]);
      src[0] <= 16'h0fff;
      pin(m[0]);
      chk("hold", 16'h0300 + 16'(m), out2Val_ff);
    end
  endtask
  task automatic t_peak();
    for (int m = 0; m < 2; m++) begin
      pin(!m[0]);
      apb(REG_PIN_FUNC, 32'(FN_RST_FALL) + 32'(m));
      pulses = 0;
      pin(m[0]);
      pin(!m[0]);
      chk("pulses", 32'h1, pulses);
    end
  endtask
  // each analog mode in turn; later modes must leave earlier values
  task automatic t_scale();
    apb(REG_SCALE_GAIN, 32'h0200);
    apb(REG_SCALE_OFFS, 32'h0010);
    for (int m = 0; m < 3; m++)
      apb(REG_PIN_FUNC, 32'(FN_SLOPE_EXT) + 32'(m));
    apb(REG_FREE_VAL, 32'h0, 1'h0);
    chk("free", 32'h0123, rdata);
    chk("scaled", 32'h02560256, {slopeVal_ff, emisVal_ff});
    apb(REG_PIN_FUNC, 32'(FN_SLOPE_EXT));
    clkEn <= 1'h0;
    pinAdc <= 16'h0200;
    pin(1'h0);
    chk("stall", 16'h0256, slopeVal_ff);
    clkEn <= 1'h1;
    pin(1'h0);
    chk("slope", 16'h0410, slopeVal_ff);
  endtask
  task automatic t_laser();
    for (int m = 0; m < 2; m++) begin
      apb(REG_PIN_FUNC, 32'(FN_LASER_LOW) + 32'(m));
      pin(m[0]);
      chk("laser on", 1'h1, laserOn_ff);
      ambientTemp <= 16'h01f5;
      pin(m[0]);
      chk("veto", 1'h0, laserOn_ff);
      ambientTemp <= 16'h01f4;
      pin(!m[0]);
      chk("laser off", 1'h0, laserOn_ff);
    end
  endtask
  task automatic t_alarm();
    for (int s = 0; s < 6; s++) src[s] <= 16'h0100;
    apb(REG_PIN_FUNC, 32'(FN_ALARM));
    apb(REG_ALARM_THR, 32'h0800);
    for (int s = 0; s < 6; s++) begin
      src[s] <= 16'h0900;
      apb(REG_ALARM_CFG, 32'(s) | 32'h10);
      @(posedge clock);
      chk("alarm src", 1'h1, ioPinOe);
      src[s] <= 16'h0100;
    end
    for (int c = 0; c < 4; c++) begin
      apb(REG_ALARM_CFG, 32'(c) << 4);
      repeat (2) @(posedge clock);
      chk("alarm sense", !c[0] ^ c[1], ioPinOe);
    end
  endtask

  // software laser request, status bits, then a mid-run reset
  task automatic t_swreset();
    apb(REG_LASER_CTL, 32'h1);
    @(posedge clock);
    chk("laser sw", 1'h1, laserOn_ff);
    apb(REG_STATUS, 32'h0, 1'h0);
    chk("status", 32'h4, rdata);
    ambientTemp <= 16'h01f5;
    repeat (2) @(posedge clock);
    chk("sw veto", 1'h0, laserOn_ff);
    ambientTemp <= 16'h01f4;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    apb(REG_PIN_FUNC, 32'h0, 1'h0);
    chk("rst func", 32'(RST_PIN_FUNC), rdata);
    apb(REG_SCALE_GAIN, 32'h0, 1'h0);
    chk("rst gain", 32'(RST_SCALE_GAIN), rdata);
    apb(REG_AMB_LIMIT, 32'h0, 1'h0);
    chk("rst limit", 32'(RST_AMB_LIMIT), rdata);
    chk("rst laser", 1'h0, laserOn_ff);
  endtask

  task automatic report_and_stop();
    $display("errors %0d of %0d checks", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    sys_rst = 1'h1;
    clkEn = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    plantLvl = 1'h1;
    ambientTemp = 16'h01f4;
    pinAdc = 16'h0123;
    for (int i = 0; i < 6; i++) src[i] = 16'h0101 * 16'(i + 1);
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    t_outsel();
    t_gate();
    t_hold();
    t_peak();
    t_scale();
    t_laser();
    t_alarm();
    t_swreset();
    report_and_stop();
  end
endmodule
